// *** design/cdb_alu.sv ***
// Purpose: shared constants and types, plus the small datapath unit that
//          computes the complement or the decrement of a file register.
// Assumes: one instruction-cycle clock; the operand is already selected.
// Notes:   the zero test is taken here so the core reads a single flag.
// How it works
// - complement file register, update zero flag
// - decrement file register into chosen destination
// - decrement and skip leaves status unchanged
// - skip only when decremented result is zero
// - skip discards fetched instruction, two cycles
// - branch literal loads program counter low bits
// - status page bits fill counter high bits
// - branch takes two cycles, flags untouched
`timescale 1ns/1ps

package cdb_pkg;
  localparam int DATA_W = 8;            // data path width
  localparam int INSTR_W = 12;          // instruction word width
  localparam int PC_W = 11;             // program counter width
  localparam int NREG = 32;             // file registers reachable
  localparam int ADDR_W = 5;            // file register select width
  localparam int LIT_W = 9;             // branch literal width
  localparam int OPC_HI = 11;           // top of the opcode field
  localparam int OPC6_LO = 6;           // low end of register-op opcode
  localparam int OPC3_LO = 9;           // low end of branch opcode
  localparam int DEST_BIT = 5;          // destination select bit
  localparam int STAT_Z = 2;            // zero flag position
  localparam int STAT_PG_HI = 6;        // upper page bit in status
  localparam int STAT_PG_LO = 5;        // lower page bit in status
  localparam logic [5:0] PAT_COMP = 6'h09;     // 0010 01
  localparam logic [5:0] PAT_DEC = 6'h03;      // 0000 11
  localparam logic [5:0] PAT_DEC_SKIP = 6'h0B; // 0010 11
  localparam logic [2:0] PAT_JUMP = 3'h5;      // 101
  localparam logic [7:0] STATUS_RST = 8'h00;   // status after reset
  localparam logic [7:0] W_RST = 8'h00;        // working register after reset
  localparam logic [7:0] FILE_RST = 8'h00;     // file registers after reset
  localparam logic [10:0] PC_RST = 11'h000;    // program counter after reset
  localparam logic [10:0] PC_STEP = 11'h001;   // sequential advance
  localparam logic [7:0] ONE = 8'h01;          // decrement step

  // operations this block executes; everything else runs as no_operation
  typedef enum logic [2:0] {
    OP_NONE,
    OP_COMP,
    OP_DEC,
    OP_DEC_SKIP,
    OP_JUMP
  } cdb_op_t;

  // decoded instruction fields travel together
  typedef struct packed {
    cdb_op_t op;
    logic to_file;
    logic [4:0] addr;
    logic [8:0] lit;
  } cdb_dec_t;
endpackage

////////////////////////////////////////////////////////////////////////////////
// complement or decrement of one operand
module cdb_alu (
  input wire cdb_pkg::cdb_op_t op,
  input wire logic [7:0] operand,
  output logic [7:0] result,
  output logic zero
);
  // complement for that op, decrement for both decrement flavours
  assign result = (op == cdb_pkg::OP_COMP) ? ~operand : operand - cdb_pkg::ONE;
  // zero test on the result, not on the operand
  assign zero = (result == 8'h00);
endmodule

// *** design/cdb_exec.sv ***
// Purpose: decode and execute complement, decrement, decrement-skip and jump.
// Assumes: INSTR is the instruction fetched at PC, same clock, one per cycle.
// Notes:   other opcodes execute as no_operation; a load port stands in for
//          the instructions that are not part of this block.
`timescale 1ns/1ps

module cdb_exec (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [11:0] INSTR,
  input wire logic LOAD_EN,
  input wire logic [4:0] LOAD_ADDR,
  input wire logic [7:0] LOAD_DATA,
  input wire logic PAGE_WR,
  input wire logic [1:0] PAGE_DATA,
  input wire logic [4:0] RD_ADDR,
  output logic [10:0] PC,
  output logic [7:0] W,
  output logic [7:0] STATUS,
  output logic FLUSH,
  output logic [7:0] RD_DATA
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] regs_q [cdb_pkg::NREG];   // file registers
  logic [7:0] w_q;                      // working register
  logic [7:0] status_q;                 // status: zero flag and page bits
  logic [10:0] pc_q;                    // program counter
  logic flush_q;                        // current fetched word is discarded
  logic [7:0] rd_q;                     // registered read port

  //////////////////////////////////////////////////////////////////////////////
  // decode
  wire [5:0] opc6 = INSTR[cdb_pkg::OPC_HI:cdb_pkg::OPC6_LO];
  wire [2:0] opc3 = INSTR[cdb_pkg::OPC_HI:cdb_pkg::OPC3_LO];
  wire is_comp = (opc6 == cdb_pkg::PAT_COMP);
  wire is_dec = (opc6 == cdb_pkg::PAT_DEC);
  wire is_dec_skip = (opc6 == cdb_pkg::PAT_DEC_SKIP);
  wire is_jump = (opc3 == cdb_pkg::PAT_JUMP);
  cdb_pkg::cdb_dec_t dec;
  cdb_pkg::cdb_op_t raw_op;
  cdb_pkg::cdb_op_t op_eff;             // operation after the discard mask

  // priority order is harmless: the patterns never overlap
  assign raw_op = is_comp ? cdb_pkg::OP_COMP :
                  is_dec ? cdb_pkg::OP_DEC :
                  is_dec_skip ? cdb_pkg::OP_DEC_SKIP :
                  is_jump ? cdb_pkg::OP_JUMP : cdb_pkg::OP_NONE;
  // a flushed word becomes no_operation whatever it holds
  assign op_eff = flush_q ? cdb_pkg::OP_NONE : raw_op;
  // one driver for the whole record, so no field has two sources
  assign dec = '{op: op_eff,
                 to_file: INSTR[cdb_pkg::DEST_BIT],
                 addr: INSTR[cdb_pkg::ADDR_W-1:0],
                 lit: INSTR[cdb_pkg::LIT_W-1:0]};

  //////////////////////////////////////////////////////////////////////////////
  // datapath
  wire [7:0] operand = regs_q[dec.addr];  // all 32 addresses are real
  logic [7:0] alu_res;
  logic alu_zero;

  cdb_alu u_alu (
    .op(dec.op),
    .operand(operand),
    .result(alu_res),
    .zero(alu_zero)
  );

  wire arith = (dec.op == cdb_pkg::OP_COMP) || (dec.op == cdb_pkg::OP_DEC) ||
               (dec.op == cdb_pkg::OP_DEC_SKIP);
  wire wr_file = arith && dec.to_file;
  wire wr_w = arith && !dec.to_file;
  // decrement-skip is deliberately absent: it touches no flag
  wire z_upd = (dec.op == cdb_pkg::OP_COMP) || (dec.op == cdb_pkg::OP_DEC);
  wire skip = (dec.op == cdb_pkg::OP_DEC_SKIP) && alu_zero;
  wire take_jump = (dec.op == cdb_pkg::OP_JUMP);
  wire [10:0] jump_pc = {status_q[cdb_pkg::STAT_PG_HI:cdb_pkg::STAT_PG_LO],
                         dec.lit};

  // next values
  wire [10:0] pc_d = take_jump ? jump_pc : pc_q + cdb_pkg::PC_STEP;
  wire flush_d = skip || take_jump;  // the fetched word is wrong in both cases
  wire [7:0] w_d = wr_w ? alu_res : w_q;
  wire [1:0] page_d = PAGE_WR ? PAGE_DATA :
                      status_q[cdb_pkg::STAT_PG_HI:cdb_pkg::STAT_PG_LO];
  wire z_d = z_upd ? alu_zero : status_q[cdb_pkg::STAT_Z];
  logic [7:0] status_d;

  // only the page bits and zero flag move here; other bits keep their value
  always_comb
  begin
    status_d = status_q;
    status_d[cdb_pkg::STAT_PG_HI:cdb_pkg::STAT_PG_LO] = page_d;
    status_d[cdb_pkg::STAT_Z] = z_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // file registers: the executing instruction wins over the load port,
  // because it reflects program order; the load is then lost
  genvar gi;
  generate
    for (gi = 0; gi < cdb_pkg::NREG; gi++)
    begin : g_reg
      wire hit_ins = wr_file && (dec.addr == 5'(gi));
      wire hit_load = LOAD_EN && (LOAD_ADDR == 5'(gi));
      wire [7:0] reg_d = hit_ins ? alu_res : hit_load ? LOAD_DATA : regs_q[gi];

      // one flop per entry
      always_ff @(posedge CLK or negedge RST_B)
      begin
        if (!RST_B)
          regs_q[gi] <= cdb_pkg::FILE_RST;
        else
          regs_q[gi] <= reg_d;
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // core registers
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      w_q <= cdb_pkg::W_RST;
      status_q <= cdb_pkg::STATUS_RST;
      pc_q <= cdb_pkg::PC_RST;
      flush_q <= 1'b0;
      rd_q <= cdb_pkg::FILE_RST;
    end
    else
    begin
      w_q <= w_d;
      status_q <= status_d;
      pc_q <= pc_d;
      flush_q <= flush_d;
      rd_q <= regs_q[RD_ADDR];
    end
  end

  // outputs straight from flops
  assign PC = pc_q;
  assign W = w_q;
  assign STATUS = status_q;
  assign FLUSH = flush_q;
  assign RD_DATA = rd_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  sequence s_skip_taken;
    (dec.op == cdb_pkg::OP_DEC_SKIP) && (operand == cdb_pkg::ONE) ##1 flush_q;
  endsequence

  sequence s_jump;
    dec.op == cdb_pkg::OP_JUMP;
  endsequence

  a_comp_to_w: assert property (
    (dec.op == cdb_pkg::OP_COMP) && !dec.to_file |=> w_q == ~$past(operand))
    else $error("complement result not in working register");

  a_comp_zero: assert property (
    (dec.op == cdb_pkg::OP_COMP) |=>
      status_q[cdb_pkg::STAT_Z] == ($past(operand) == 8'hFF))
    else $error("complement zero flag wrong");

  a_dec_to_w: assert property (
    (dec.op == cdb_pkg::OP_DEC) && !dec.to_file |=>
      (w_q == 8'($past(operand) - cdb_pkg::ONE)) &&
      (status_q[cdb_pkg::STAT_Z] == (w_q == 8'h00)))
    else $error("decrement to working register wrong");

  a_dec_keeps_w: assert property (
    arith && dec.to_file |=> $stable(w_q))
    else $error("file destination disturbed working register");

  a_skip_flags: assert property (
    (dec.op == cdb_pkg::OP_DEC_SKIP) |=> $stable(status_q[cdb_pkg::STAT_Z]))
    else $error("decrement-skip changed zero flag");

  a_skip_when_zero: assert property (
    (dec.op == cdb_pkg::OP_DEC_SKIP) |=> flush_q == ($past(operand) == cdb_pkg::ONE))
    else $error("skip decision wrong");

  a_skip_nop: assert property (
    s_skip_taken |=> !flush_q && $stable(w_q))
    else $error("discarded instruction had an effect");

  a_jump_target: assert property (
    s_jump |=> pc_q == {$past(status_q[6:5]), $past(INSTR[8:0])})
    else $error("jump target wrong");

  a_jump_two: assert property (
    s_jump |=> flush_q && $stable(status_q[cdb_pkg::STAT_Z]) ##1 !flush_q)
    else $error("jump did not take two cycles");

  // complement written back lands in the addressed register
  a_comp_to_file: assert property (
    (dec.op == cdb_pkg::OP_COMP) && dec.to_file |=>
      regs_q[$past(dec.addr)] == ~$past(operand))
    else $error("complement result not in file register");

  // decrement written back lands in the addressed register
  a_dec_to_file: assert property (
    (dec.op == cdb_pkg::OP_DEC) && dec.to_file |=>
      regs_q[$past(dec.addr)] == 8'($past(operand) - cdb_pkg::ONE))
    else $error("decrement to file register wrong");

  // decrement-skip still delivers its result to the working register
  a_skip_to_w: assert property (
    (dec.op == cdb_pkg::OP_DEC_SKIP) && !dec.to_file |=>
      w_q == 8'($past(operand) - cdb_pkg::ONE))
    else $error("decrement-skip result not in working register");

  // any discarded word, after a skip or a jump, leaves no trace
  a_flush_inert: assert property (
    flush_q |=> $stable(w_q) && $stable(status_q[cdb_pkg::STAT_Z]))
    else $error("discarded word changed state");

  // every cycle that does not jump advances the counter by one
  a_pc_advance: assert property (
    !take_jump |=> pc_q == 11'($past(pc_q) + cdb_pkg::PC_STEP))
    else $error("program counter did not advance");

endmodule

// *** tb/cdb_exec_test.sv ***
// Purpose: self-checking bench for the complement, decrement, skip and jump executor.
// Assumes: inputs change 1 ns after the rising edge; outputs are settled by then.
// Notes:   a reference model in the bench predicts PC, W, STATUS, FLUSH and RD_DATA.
`timescale 1ns/1ps

module complement_decrement_branch_exec_test;
  logic CLK, RST_B, LOAD_EN, PAGE_WR, FLUSH; // design pins
  logic [11:0] INSTR; // instruction word under test
  logic [4:0] LOAD_ADDR, RD_ADDR; // load and debug read addresses
  logic [7:0] LOAD_DATA, W, STATUS, RD_DATA; // data pins
  logic [1:0] PAGE_DATA; // page bits to status
  logic [10:0] PC; // program counter seen
  logic [7:0] file_m [32]; // expected file registers
  logic [7:0] w_m, st_m, rd_m; // expected working, status, read-back
  logic [10:0] pc_m; // expected counter
  logic fl_m; // expected discard flag
  int n_errors, n_compared, seed; // bookkeeping
  logic [31:0] r; // random draw
  logic [11:0] ins; // random instruction, handed to the cycle task

  cdb_exec u_dut (.CLK(CLK), .RST_B(RST_B), .INSTR(INSTR), .LOAD_EN(LOAD_EN),
    .LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA), .PAGE_WR(PAGE_WR),
    .PAGE_DATA(PAGE_DATA), .RD_ADDR(RD_ADDR), .PC(PC), .W(W), .STATUS(STATUS),
    .FLUSH(FLUSH), .RD_DATA(RD_DATA));

  //////////////////////////////////////////////////////////////////////////////
  // clock: 5 ns period
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // one comparison; case inequality so an unknown never matches
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // verdict and end of run, shared by the main flow and the watchdog
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // model state after reset: everything cleared
  task automatic model_reset;
    foreach (file_m[i]) file_m[i] = 8'h00;
    w_m = 8'h00;
    st_m = 8'h00;
    rd_m = 8'h00;
    pc_m = 11'h000;
    fl_m = 1'b0;
  endtask

  // predict one edge from the inputs held across it
  task automatic model_step;
    logic [7:0] f, res;
    logic wr;
    f = file_m[INSTR[4:0]];
    wr = 1'b0;
    res = 8'h00;
    rd_m = file_m[RD_ADDR];
    // load first so a same-cycle instruction write wins
    if (LOAD_EN) file_m[LOAD_ADDR] = LOAD_DATA;
    if (fl_m)
    begin
      fl_m = 1'b0; // discarded word runs as no_operation
      pc_m = pc_m + 11'h001;
    end
    else
    begin
      pc_m = pc_m + 11'h001;
      if (INSTR[11:6] == cdb_pkg::PAT_COMP)
      begin
        res = ~f;
        wr = 1'b1;
        st_m[2] = (res == 8'h00);
      end
      else if (INSTR[11:6] == cdb_pkg::PAT_DEC)
      begin
        res = f - 8'h01;
        wr = 1'b1;
        st_m[2] = (res == 8'h00);
      end
      else if (INSTR[11:6] == cdb_pkg::PAT_DEC_SKIP)
      begin
        res = f - 8'h01; // flags untouched
        wr = 1'b1;
        fl_m = (res == 8'h00);
      end
      else if (INSTR[11:9] == cdb_pkg::PAT_JUMP)
      begin
        pc_m = {st_m[6:5], INSTR[8:0]};
        fl_m = 1'b1; // second cycle
      end
      if (wr && INSTR[5]) file_m[INSTR[4:0]] = res;
      else if (wr) w_m = res;
    end
    // page write lands after the jump used the old bits
    if (PAGE_WR) st_m[6:5] = PAGE_DATA;
  endtask

  // compare all outputs against the model
  task automatic check_all;
    check("PC", PC, pc_m);
    check("W", {3'h0, W}, {3'h0, w_m});
    check("STATUS", {3'h0, STATUS}, {3'h0, st_m});
    check("FLUSH", {10'h000, FLUSH}, {10'h000, fl_m});
    check("RD_DATA", {3'h0, RD_DATA}, {3'h0, rd_m});
  endtask

  // drive one instruction cycle, then compare just after the edge
  task automatic cycle(input logic [11:0] i, input logic le, input logic [4:0] la,
                       input logic [7:0] ld, input logic pw, input logic [1:0] pd,
                       input logic [4:0] ra);
    INSTR = i;
    LOAD_EN = le;
    LOAD_ADDR = la;
    LOAD_DATA = ld;
    PAGE_WR = pw;
    PAGE_DATA = pd;
    RD_ADDR = ra;
    @(posedge CLK);
    model_step;
    #1;
    check_all;
  endtask

  // asynchronous reset held two cycles, outputs checked while held
  task automatic do_reset;
    RST_B = 1'b0;
    model_reset;
    repeat (2) @(posedge CLK);
    #1;
    check_all;
    RST_B = 1'b1;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: the run needs about 1500 cycles, so 40 us is ample
  initial
  begin
    #40000;
    n_errors++;
    stop_test;
  end

  // main sequence: corner cases, then a seeded random stream
  initial
  begin
    seed = 14;
    n_errors = 0;
    n_compared = 0;
    {INSTR, LOAD_EN, LOAD_ADDR, LOAD_DATA, PAGE_WR, PAGE_DATA, RD_ADDR} = '0;
    #1;
    do_reset;
    cycle(12'h000, 1'b1, 5'h03, 8'h13, 1'b1, 2'h3, 5'h03); // load 0x13, pages 11
    cycle({cdb_pkg::PAT_COMP, 6'h03}, 1'b0, 5'h00, 8'h00, 1'b0, 2'h0, 5'h03);
    cycle(12'h000, 1'b1, 5'h1F, 8'h01, 1'b0, 2'h0, 5'h1F); // top address holds 1
    cycle({cdb_pkg::PAT_DEC_SKIP, 6'h3F}, 1'b0, 5'h00, 8'h00, 1'b0, 2'h0, 5'h1F);
    cycle({cdb_pkg::PAT_JUMP, 9'h1FF}, 1'b0, 5'h00, 8'h00, 1'b0, 2'h0, 5'h1F);
    cycle({cdb_pkg::PAT_JUMP, 9'h155}, 1'b0, 5'h00, 8'h00, 1'b1, 2'h1, 5'h1F);
    cycle({cdb_pkg::PAT_JUMP, 9'h0AA}, 1'b0, 5'h00, 8'h00, 1'b0, 2'h0, 5'h1F);
    cycle({cdb_pkg::PAT_DEC, 6'h1F}, 1'b1, 5'h04, 8'hFF, 1'b0, 2'h0, 5'h04);
    cycle({cdb_pkg::PAT_COMP, 6'h24}, 1'b1, 5'h04, 8'h77, 1'b0, 2'h0, 5'h04);
    cycle({cdb_pkg::PAT_DEC_SKIP, 6'h04}, 1'b0, 5'h00, 8'h00, 1'b0, 2'h0, 5'h04);
    for (int n = 0; n < 1500; n++)
    begin
      r = $random(seed);
      if (n == 700) do_reset;
      case (r[31:29] % 5)
        0: ins = {cdb_pkg::PAT_COMP, r[5:0]};
        1: ins = {cdb_pkg::PAT_DEC, r[5:0]};
        2: ins = {cdb_pkg::PAT_DEC_SKIP, r[5:0]};
        3: ins = {cdb_pkg::PAT_JUMP, r[8:0]};
        default: ins = r[11:0];
      endcase
      // small load values make zero results and skips frequent
      cycle(ins, r[12], r[17:13], r[18] ? 8'h01 : r[26:19], r[27], r[2:1], r[4:0]);
    end
    stop_test;
  end
endmodule
